// >>> rtl/ucd_pkg.sv
package ucd_pkg;
   // ----------------------------------------------------------------
   // software port map
   // ----------------------------------------------------------------
   localparam logic [15:0] BUFCTL_ADDR = 16'hFF8B;
   localparam logic [7:0] BUFCTL_RST = 8'h00;
   localparam logic [7:0] BUFCTL_MASK = 8'h03;
   localparam int BC_EN_BIT = 1;
   localparam int BC_GUARD_DIS_BIT = 0;
   localparam logic [15:0] STORE_BASE = 16'hF9E3;
   localparam int STORE_BYTES = 256;
   localparam logic [15:0] EP0CTL_ADDR = 16'hFFA0;
   localparam int NAK_BIT = 0;
   localparam logic [15:0] INT_STAT_ADDR = 16'hFFA1;
   localparam logic [15:0] INT_MASK_ADDR = 16'hFFA2;
   localparam logic [15:0] TLEN_LO_ADDR = 16'hFFA3;
   localparam logic [15:0] TLEN_HI_ADDR = 16'hFFA4;
   localparam logic [15:0] MAXPWR_ADDR = 16'hFFA5;
   localparam logic [15:0] EP1ADDR_ADDR = 16'hFFA6;
   localparam logic [15:0] EP1MPS_LO_ADDR = 16'hFFA7;
   localparam logic [15:0] EP1MPS_HI_ADDR = 16'hFFA8;
   localparam logic [15:0] EP1IVL_ADDR = 16'hFFA9;
   // ----------------------------------------------------------------
   // event bits, status and mask share this layout
   // ----------------------------------------------------------------
   localparam int EV_W = 4;
   localparam int EV_VBUS = 0;
   localparam int EV_RESET = 1;
   localparam int EV_SUSP = 2;
   localparam int EV_RESUME = 3;
   // ----------------------------------------------------------------
   // descriptor image layout
   // ----------------------------------------------------------------
   localparam logic [3:0] CFG_LEN = 4'h9;
   localparam logic [3:0] IF_LEN = 4'h9;
   localparam logic [3:0] EP_LEN = 4'h7;
   localparam logic [3:0] CFG_TLEN_LO = 4'h2;
   localparam logic [3:0] CFG_TLEN_HI = 4'h3;
   localparam logic [3:0] CFG_NUMIF = 4'h4;
   localparam logic [3:0] CFG_VALUE = 4'h5;
   localparam logic [3:0] CFG_ATTR = 4'h7;
   localparam logic [3:0] CFG_MAXPWR = 4'h8;
   localparam logic [3:0] IF_NUM = 4'h2;
   localparam logic [3:0] IF_NEP = 4'h4;
   localparam logic [3:0] IF_CLASS = 4'h5;
   localparam logic [3:0] EP_ADDR = 4'h2;
   localparam logic [3:0] EP_ATTR = 4'h3;
   localparam logic [3:0] EP_MPS_LO = 4'h4;
   localparam logic [3:0] EP_MPS_HI = 4'h5;
   localparam logic [3:0] EP_INTERVAL = 4'h6;
   // first endpoint image when one interface leads the store
   localparam logic [7:0] EP1_BASE = 8'h12;
   // ----------------------------------------------------------------
   // host fetch timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int HOST_WAIT_NS = 400;
   localparam int HOST_WAIT_CYC = HOST_WAIT_NS * CLK_MHZ / 1000;
endpackage

// >>> rtl/ucd_link_if.sv
`timescale 1ns/1ps
interface ucd_link_if;
   logic vbus;
   logic line_reset;
   logic line_suspend;
   logic line_resume;
   logic desc_req;
   logic [7:0] desc_addr;
   logic desc_ack;
   logic [7:0] desc_data;
   modport dev (
      input vbus,
      input line_reset,
      input line_suspend,
      input line_resume,
      input desc_req,
      input desc_addr,
      output desc_ack,
      output desc_data
   );
   modport host (
      output vbus,
      output line_reset,
      output line_suspend,
      output line_resume,
      output desc_req,
      output desc_addr,
      input desc_ack,
      input desc_data
   );
endinterface

// >>> rtl/ucd_dev.sv
`timescale 1ns/1ps
// Contract
// - config image: nine bytes, fixed field order
// - total length little-endian at offsets 2, 3
// - offset 8 holds maximum power
// - interface image: nine bytes, fixed order
// - endpoint image: seven bytes, fixed order
// - max transfer size low 4, high 5
// - offsets 2,3,6: address, type, interval
// - byte control register FF8B, resets 00
// - bit 1 enables the input buffer
// - software clears enable when USB unused
// - bit 0 set disables floating guard
// - guard blocks line events without cable
// - guard off: software watches bus power
// - on detach mask, disable, guard on
// - on attach unmask, flush, reinitialize
// - images stored consecutively, each interface then its endpoints
// - store writes only while nak-all set
module ucd_dev
   import ucd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   ucd_link_if.dev link,
   input wire logic [15:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   output logic usb_irq,
   output logic input_buffer_enable,
   output logic float_guard_active,
   output logic [15:0] total_length,
   output logic [7:0] max_power
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] bufctl;
      logic nak_all;
      logic [EV_W-1:0] int_stat;
      logic [EV_W-1:0] int_mask;
      logic [7:0] rdata;
      logic ack;
      logic [7:0] ddata;
      logic [EV_W-1:0] sync1;
      logic [EV_W-1:0] sync2;
      logic [EV_W-1:0] prev;
      logic [STORE_BYTES-1:0][7:0] store;
   } ucd_dev_s;

   ucd_dev_s r;
   ucd_dev_s n;
   logic [EV_W-1:0] rise;
   logic [EV_W-1:0] ev;
   logic allow;

   // ----------------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------------
   function automatic logic store_hit(input logic [15:0] a);
      logic [16:0] top;
      top = {1'b0, STORE_BASE} + 17'(STORE_BYTES);
      store_hit = ({1'b0, a} >= {1'b0, STORE_BASE}) && ({1'b0, a} < top);
   endfunction

   function automatic logic [7:0] store_idx(input logic [15:0] a);
      logic [15:0] d;
      d = a - STORE_BASE;
      store_idx = d[7:0];
   endfunction

   // ----------------------------------------------------------------
   // line event qualification
   // ----------------------------------------------------------------
   always_comb
   begin
      rise = r.sync2 & ~r.prev;
      // reset, suspend and resume events count only with the buffer on and, with guard on, a cable; vbus changes always count
      allow = r.bufctl[BC_EN_BIT] & (r.bufctl[BC_GUARD_DIS_BIT] | r.sync2[EV_VBUS]);
      ev = '0;
      ev[EV_VBUS] = r.sync2[EV_VBUS] ^ r.prev[EV_VBUS];
      ev[EV_RESET] = allow & rise[EV_RESET];
      ev[EV_SUSP] = allow & rise[EV_SUSP];
      ev[EV_RESUME] = allow & rise[EV_RESUME];
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n = r;
      n.ack = 1'b0;
      n.rdata = 8'h00;
      n.sync1 = {link.line_resume, link.line_suspend, link.line_reset, link.vbus};
      n.sync2 = r.sync1;
      n.prev = r.sync2;

      if (sw_wr)
      begin
         case (sw_addr)
            BUFCTL_ADDR:
            begin
               n.bufctl = sw_wdata & BUFCTL_MASK;
            end
            EP0CTL_ADDR:
            begin
               n.nak_all = sw_wdata[NAK_BIT];
            end
            INT_STAT_ADDR:
            begin
               n.int_stat = r.int_stat & ~sw_wdata[EV_W-1:0];
            end
            INT_MASK_ADDR:
            begin
               n.int_mask = sw_wdata[EV_W-1:0];
            end
            default:
            begin
               if (store_hit(sw_addr) && r.nak_all)
               begin
                  n.store[store_idx(sw_addr)] = sw_wdata;
               end
            end
         endcase
      end

      // a new event wins over a clear in the same cycle
      n.int_stat = n.int_stat | ev;

      if (sw_rd)
      begin
         case (sw_addr)
            BUFCTL_ADDR:
            begin
               n.rdata = r.bufctl & BUFCTL_MASK;
            end
            EP0CTL_ADDR:
            begin
               n.rdata = {7'h00, r.nak_all};
            end
            INT_STAT_ADDR:
            begin
               n.rdata = {4'h0, r.int_stat};
            end
            INT_MASK_ADDR:
            begin
               n.rdata = {4'h0, r.int_mask};
            end
            TLEN_LO_ADDR:
            begin
               n.rdata = r.store[CFG_TLEN_LO];
            end
            TLEN_HI_ADDR:
            begin
               n.rdata = r.store[CFG_TLEN_HI];
            end
            MAXPWR_ADDR:
            begin
               n.rdata = r.store[CFG_MAXPWR];
            end
            EP1ADDR_ADDR:
            begin
               n.rdata = r.store[EP1_BASE + 8'(EP_ADDR)];
            end
            EP1MPS_LO_ADDR:
            begin
               n.rdata = r.store[EP1_BASE + 8'(EP_MPS_LO)];
            end
            EP1MPS_HI_ADDR:
            begin
               n.rdata = r.store[EP1_BASE + 8'(EP_MPS_HI)];
            end
            EP1IVL_ADDR:
            begin
               n.rdata = r.store[EP1_BASE + 8'(EP_INTERVAL)];
            end
            default:
            begin
               if (store_hit(sw_addr))
               begin
                  n.rdata = r.store[store_idx(sw_addr)];
               end
            end
         endcase
      end

      // descriptor bytes go out only with the buffer on and no rewrite underway
      if (link.desc_req && r.bufctl[BC_EN_BIT] && !r.nak_all)
      begin
         n.ack = 1'b1;
         n.ddata = r.store[link.desc_addr];
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r <= '0;
         r.bufctl <= BUFCTL_RST;
      end
      else
      begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign sw_rdata = r.rdata;
   assign usb_irq = |(r.int_stat & r.int_mask);
   assign input_buffer_enable = r.bufctl[BC_EN_BIT];
   assign float_guard_active = ~r.bufctl[BC_GUARD_DIS_BIT];
   assign total_length = {r.store[CFG_TLEN_HI], r.store[CFG_TLEN_LO]};
   assign max_power = r.store[CFG_MAXPWR];
   assign link.desc_ack = r.ack;
   assign link.desc_data = r.ddata;

endmodule // ucd_dev

// >>> rtl/ucd_host.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
module ucd_host
   import ucd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   ucd_link_if.host link,
   input wire logic attach,
   input wire logic line_reset_in,
   input wire logic line_suspend_in,
   input wire logic line_resume_in,
   input wire logic fetch,
   output logic busy,
   output logic done,
   output logic fetch_err,
   output logic [15:0] cfg_total_len,
   output logic [7:0] cfg_num_if,
   output logic [7:0] cfg_value,
   output logic [7:0] cfg_attr,
   output logic [7:0] cfg_max_power,
   output logic [7:0] if_count,
   output logic [7:0] if_class,
   output logic [7:0] ep_count,
   output logic [7:0] ep_addr,
   output logic [7:0] ep_attr,
   output logic [15:0] ep_mps,
   output logic [7:0] ep_interval
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01, H_DONE = 2'b11} ucd_host_e;
   typedef enum logic [1:0] {K_CFG = 2'b00, K_IF = 2'b01, K_EP = 2'b11} ucd_kind_e;

   typedef struct packed {
      ucd_host_e st;
      ucd_kind_e kind;
      logic [8:0] idx;
      logic [8:0] limit;
      logic [3:0] off;
      logic [7:0] ep_left;
      logic [7:0] tmr;
      logic err;
      logic req;
      logic [7:0] addr;
      logic [3:0] lines;
      logic [15:0] tlen;
      logic [7:0] num_if;
      logic [7:0] value;
      logic [7:0] attr;
      logic [7:0] maxpwr;
      logic [7:0] ifs;
      logic [7:0] ifcls;
      logic [7:0] eps;
      logic [7:0] epa;
      logic [7:0] ept;
      logic [15:0] mps;
      logic [7:0] ivl;
   } ucd_host_s;

   ucd_host_s r;
   ucd_host_s n;
   logic [7:0] b;
   logic [8:0] nidx;

   function automatic logic [3:0] img_len(input ucd_kind_e k);
      case (k)
         K_CFG: img_len = CFG_LEN;
         K_IF: img_len = IF_LEN;
         default: img_len = EP_LEN;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n = r;
      b = link.desc_data;
      nidx = r.idx + 9'h001;
      n.req = 1'b0;
      // lines pass even with no cable, as floating noise would
      n.lines = {attach, line_resume_in, line_suspend_in, line_reset_in};
      case (r.st)
         H_IDLE, H_DONE:
         begin
            if (fetch && attach)
            begin
               n = r;
               n.req = 1'b1;
               n.lines = {attach, line_resume_in, line_suspend_in, line_reset_in};
               n.st = H_WAIT;
               n.kind = K_CFG;
               n.idx = 9'h000;
               n.addr = 8'h00;
               n.limit = {5'h00, CFG_LEN};
               n.off = 4'h0;
               n.tmr = 8'h00;
               n.err = 1'b0;
               n.ifs = 8'h00;
               n.eps = 8'h00;
            end
         end
         H_WAIT:
         begin
            n.tmr = r.tmr + 8'h01;
            if (!attach || r.tmr == 8'(HOST_WAIT_CYC))
            begin
               n.err = 1'b1;
               n.st = H_DONE;
            end
            else if (link.desc_ack)
            begin
               n.tmr = 8'h00;
               case (r.kind)
                  K_CFG:
                  begin
                     case (r.off)
                        CFG_TLEN_LO: n.tlen[7:0] = b;
                        CFG_TLEN_HI:
                        begin
                           n.tlen[15:8] = b;
                           if ({b, r.tlen[7:0]} > 16'(STORE_BYTES))
                              n.limit = 9'(STORE_BYTES);
                           else
                              n.limit = {b[0], r.tlen[7:0]};
                        end
                        CFG_NUMIF: n.num_if = b;
                        CFG_VALUE: n.value = b;
                        CFG_ATTR: n.attr = b;
                        CFG_MAXPWR: n.maxpwr = b;
                        default: n.num_if = n.num_if;
                     endcase
                  end
                  K_IF:
                  begin
                     case (r.off)
                        IF_NUM: n.ifs = r.ifs + 8'h01;
                        IF_NEP: n.ep_left = b;
                        IF_CLASS: n.ifcls = b;
                        default: n.ifcls = n.ifcls;
                     endcase
                  end
                  default:
                  begin
                     case (r.off)
                        EP_ADDR:
                        begin
                           n.eps = r.eps + 8'h01;
                           n.epa = b;
                        end
                        EP_ATTR: n.ept = b;
                        EP_MPS_LO: n.mps[7:0] = b;
                        EP_MPS_HI: n.mps[15:8] = b;
                        EP_INTERVAL: n.ivl = b;
                        default: n.ivl = n.ivl;
                     endcase
                  end
               endcase
               // walk the consecutive images
               n.off = r.off + 4'h1;
               if (r.off == img_len(r.kind) - 4'h1)
               begin
                  n.off = 4'h0;
                  case (r.kind)
                     K_CFG: n.kind = K_IF;
                     K_IF: n.kind = (r.ep_left != 8'h00) ? K_EP : K_IF;
                     default:
                     begin
                        n.ep_left = r.ep_left - 8'h01;
                        n.kind = (r.ep_left > 8'h01) ? K_EP : K_IF;
                     end
                  endcase
               end
               n.idx = nidx;
               if (nidx >= n.limit)
                  n.st = H_DONE;
               else
               begin
                  n.req = 1'b1;
                  n.addr = nidx[7:0];
               end
            end
         end
         default: n.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         r <= '0;
      else
         r <= n;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.vbus = r.lines[3];
   assign link.line_resume = r.lines[2];
   assign link.line_suspend = r.lines[1];
   assign link.line_reset = r.lines[0];
   assign link.desc_req = r.req;
   assign link.desc_addr = r.addr;
   assign busy = (r.st == H_WAIT);
   assign done = (r.st == H_DONE);
   assign fetch_err = r.err;
   assign cfg_total_len = r.tlen;
   assign cfg_num_if = r.num_if;
   assign cfg_value = r.value;
   assign cfg_attr = r.attr;
   assign cfg_max_power = r.maxpwr;
   assign if_count = r.ifs;
   assign if_class = r.ifcls;
   assign ep_count = r.eps;
   assign ep_addr = r.epa;
   assign ep_attr = r.ept;
   assign ep_mps = r.mps;
   assign ep_interval = r.ivl;

endmodule // ucd_host

// >>> dv/ucd_props.sv
`timescale 1ns/1ps
module ucd_props (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic vbus,
   input wire logic line_reset,
   input wire logic desc_req,
   input wire logic [7:0] desc_addr,
   input wire logic desc_ack,
   input wire logic [7:0] desc_data
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // descriptor fetch handshake
   // ----------------------------------------------------------------
   property p_ack_cause;
      desc_ack |-> $past(desc_req);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_ack_pulse;
      desc_ack |=> !desc_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   property p_req_pulse;
      desc_req |=> !desc_req;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request longer than a cycle");
   property p_data_hold;
      !desc_ack |-> $stable(desc_data);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved without ack");
   property p_next_addr;
      desc_req ##1 desc_ack ##1 desc_req |-> desc_addr == $past(desc_addr, 2) + 8'h01;
   endproperty
   a_next_addr: assert property (p_next_addr) else $error("byte index skipped");
   property p_first_addr;
      desc_req && !$past(desc_ack) |-> desc_addr == 8'h00;
   endproperty
   a_first_addr: assert property (p_first_addr) else $error("walk not from byte 0");
   sequence s_refused;
      desc_req ##1 !desc_ack;
   endsequence
   property p_no_retry;
      s_refused |=> !desc_req [*8];
   endproperty
   a_no_retry: assert property (p_no_retry) else $error("request repeated early");
   property p_req_attached;
      desc_req |-> vbus;
   endproperty
   a_req_attached: assert property (p_req_attached) else $error("request without cable");
   c_acked: cover property (desc_req ##1 desc_ack);
   c_refused: cover property (s_refused);
   c_line_reset: cover property ($rose(line_reset));
endmodule // ucd_props

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import ucd_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] sw_addr = 16'h0000;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic attach = 1'b0;
   logic [2:0] line_in = 3'h0;
   logic fetch = 1'b0;
   logic [7:0] sw_rdata, max_power, num_if, cfg_value, cfg_attr, cfg_mp, if_count, if_class;
   logic [7:0] ep_count, ep_addr, ep_attr, ep_interval;
   logic [15:0] total_length, cfg_total_len, ep_mps;
   logic usb_irq, buf_en, guard_on, busy, done, fetch_err;
   logic [7:0] img [0:24];
   logic [7:0] rv;
   int fails = 0;
   int check_count = 0;
   int k;
   int it;
   always #12.5 clk = ~clk;
   ucd_link_if i_ucd_link_if();
   ucd_dev i_ucd_dev(.clk(clk), .arst_n(arst_n), .link(i_ucd_link_if), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .usb_irq(usb_irq),
      .input_buffer_enable(buf_en), .float_guard_active(guard_on),
      .total_length(total_length), .max_power(max_power));
   ucd_host i_ucd_host(.clk(clk), .arst_n(arst_n), .link(i_ucd_link_if), .attach(attach),
      .line_reset_in(line_in[0]), .line_suspend_in(line_in[1]), .line_resume_in(line_in[2]),
      .fetch(fetch), .busy(busy), .done(done), .fetch_err(fetch_err),
      .cfg_total_len(cfg_total_len), .cfg_num_if(num_if), .cfg_value(cfg_value),
      .cfg_attr(cfg_attr), .cfg_max_power(cfg_mp), .if_count(if_count), .if_class(if_class),
      .ep_count(ep_count), .ep_addr(ep_addr), .ep_attr(ep_attr), .ep_mps(ep_mps),
      .ep_interval(ep_interval));
   ucd_props i_ucd_props(.clk(clk), .arst_n(arst_n), .vbus(i_ucd_link_if.vbus),
      .line_reset(i_ucd_link_if.line_reset), .desc_req(i_ucd_link_if.desc_req),
      .desc_addr(i_ucd_link_if.desc_addr), .desc_ack(i_ucd_link_if.desc_ack),
      .desc_data(i_ucd_link_if.desc_data));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] le16(input logic [7:0] lo, input logic [7:0] hi);
      return {hi, lo};
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
      // let the write settle before anyone looks at the outputs
      #1;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 rv = sw_rdata;
      check("sw_rdata", 16'(rv), 16'(e));
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      line_in[b] <= 1'b1;
      repeat (8) @(posedge clk);
      line_in[b] <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   task automatic run_fetch(input logic err);
      int n;
      @(posedge clk);
      fetch <= 1'b1;
      @(posedge clk);
      fetch <= 1'b0;
      #1;
      for (n = 0; n < 3000 && busy !== 1'b0; n++)
         @(posedge clk);
      if (n == 3000)
      begin
         fails++;
         final_report();
      end
      #1 check("fetch_err", 16'(fetch_err), 16'(err));
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(97776));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      rc(BUFCTL_ADDR, BUFCTL_RST);
      rc(EP0CTL_ADDR, 8'h00);
      rc(INT_MASK_ADDR, 8'h00);
      rc(16'h1234, 8'h00);
      wr(BUFCTL_ADDR, 8'hFF);
      rc(BUFCTL_ADDR, BUFCTL_MASK);
      @(posedge clk);
      #1 check("sw_rdata idle", 16'(sw_rdata), 16'h0000);
      check("buf_en", 16'(buf_en), 16'h0001);
      check("guard", 16'(guard_on), 16'h0000);
      wr(BUFCTL_ADDR, 8'h02);
      check("guard", 16'(guard_on), 16'h0001);
      pulse(0);
      rc(INT_STAT_ADDR, 8'h00);
      wr(BUFCTL_ADDR, 8'h03);
      pulse(0);
      rc(INT_STAT_ADDR, 8'h02);
      check("irq", 16'(usb_irq), 16'h0000);
      wr(INT_MASK_ADDR, 8'h02);
      check("irq", 16'(usb_irq), 16'h0001);
      wr(INT_STAT_ADDR, 8'h02);
      rc(INT_STAT_ADDR, 8'h00);
      check("irq", 16'(usb_irq), 16'h0000);
      @(posedge clk) attach <= 1'b1;
      wr(BUFCTL_ADDR, 8'h02);
      repeat (8) @(posedge clk);
      rc(INT_STAT_ADDR, 8'h01);
      wr(INT_STAT_ADDR, 8'h01);
      for (k = 1; k < 4; k++)
      begin
         pulse(k - 1);
         rc(INT_STAT_ADDR, 8'(1 << k));
         wr(INT_STAT_ADDR, 8'h0F);
      end
      wr(BUFCTL_ADDR, 8'h00);
      pulse(1);
      rc(INT_STAT_ADDR, 8'h00);
      run_fetch(1'b1);
      wr(BUFCTL_ADDR, 8'h02);
      wr(STORE_BASE, 8'h5A);
      rc(STORE_BASE, 8'h00);
      for (it = 0; it < 3; it++)
      begin
         for (k = 0; k < 25; k++)
            img[k] = 8'($urandom);
         img[0] = 8'h09;
         img[2] = 8'h19;
         img[3] = 8'h00;
         img[4] = 8'h01;
         img[9] = 8'h09;
         img[13] = 8'h01;
         img[18] = 8'h07;
         if (it == 0)
            img[23] = 8'hFF;
         wr(EP0CTL_ADDR, 8'h01);
         rc(EP0CTL_ADDR, 8'h01);
         for (k = 0; k < 25; k++)
            wr(STORE_BASE + 16'(k), img[k]);
         rc(STORE_BASE + 16'h0008, img[8]);
         run_fetch(1'b1);
         wr(EP0CTL_ADDR, 8'h00);
         check("total_length", total_length, le16(img[2], img[3]));
         check("max_power", 16'(max_power), 16'(img[8]));
         rc(EP1ADDR_ADDR, img[20]);
         rc(EP1MPS_HI_ADDR, img[23]);
         rc(EP1IVL_ADDR, img[24]);
         rc(TLEN_LO_ADDR, img[2]);
         rc(TLEN_HI_ADDR, img[3]);
         rc(MAXPWR_ADDR, img[8]);
         rc(EP1MPS_LO_ADDR, img[22]);
         run_fetch(1'b0);
         check("done", 16'(done), 16'h0001);
         check("cfg_total_len", cfg_total_len, le16(img[2], img[3]));
         check("cfg_num_if", 16'(num_if), 16'(img[4]));
         check("cfg_value", 16'(cfg_value), 16'(img[5]));
         check("cfg_attr", 16'(cfg_attr), 16'(img[7]));
         check("cfg_max_power", 16'(cfg_mp), 16'(img[8]));
         check("if_count", 16'(if_count), 16'h0001);
         check("if_class", 16'(if_class), 16'(img[14]));
         check("ep_count", 16'(ep_count), 16'h0001);
         check("ep_addr", 16'(ep_addr), 16'(img[20]));
         check("ep_attr", 16'(ep_attr), 16'(img[21]));
         check("ep_mps", ep_mps, le16(img[22], img[23]));
         check("ep_interval", 16'(ep_interval), 16'(img[24]));
      end
      // detach: mask, disable buffer, guard on
      wr(INT_MASK_ADDR, 8'h00);
      wr(BUFCTL_ADDR, 8'h00);
      @(posedge clk) attach <= 1'b0;
      repeat (8) @(posedge clk);
      rc(INT_STAT_ADDR, 8'h01);
      check("irq", 16'(usb_irq), 16'h0000);
      final_report();
   end
endmodule // tb_top
